// ==== logic/status_cell.sv ====
// Generic 16-bit status register cell: condition, filters, event, enable, summary
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_cell #(
    parameter int WIDTH = `CELL_WIDTH
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic [WIDTH-1:0]    condition_in,
    input  wire status_pkg::reg_req_t req,
    output logic      [WIDTH-1:0]    rdata,
    output logic                     summary
);
    import status_pkg::*;

    // Bit 15 mask and part layout assume the 16-bit cell
    if (WIDTH != 16) begin : g_width_check
        $error("status_cell: WIDTH must be 16");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cond;
        logic [WIDTH-1:0] rise_filter;
        logic [WIDTH-1:0] falling_transition_filter;
        logic [WIDTH-1:0] event_bits;
        logic [WIDTH-1:0] event_enable_part;
        logic [WIDTH-1:0] rdata;
    } cell_state_t;

    cell_state_t state_q;
    cell_state_t state_d;
    logic [WIDTH-1:0] cond_masked;
    logic [WIDTH-1:0] hits;

    always_comb begin
        cond_masked = condition_in & WIDTH'(`CELL_MSB_ZERO_MASK);
        hits = (cond_masked & ~state_q.cond & state_q.rise_filter)
             | (~cond_masked & state_q.cond & state_q.falling_transition_filter);
        state_d = state_q;
        state_d.cond = cond_masked;
        if (req.rd) begin
            unique case (req.sel)
                `PART_CONDITION: state_d.rdata = state_q.cond;
                `PART_RISE:      state_d.rdata = state_q.rise_filter;
                `PART_FALL:      state_d.rdata = state_q.falling_transition_filter;
                `PART_EVENT:     state_d.rdata = state_q.event_bits;
                `PART_ENABLE:    state_d.rdata = state_q.event_enable_part;
                default:         state_d.rdata = '0;
            endcase
        end
        if (req.wr) begin
            unique case (req.sel)
                `PART_RISE:   state_d.rise_filter = req.wdata[WIDTH-1:0] & WIDTH'(`CELL_MSB_ZERO_MASK);
                `PART_FALL:   state_d.falling_transition_filter =
                                  req.wdata[WIDTH-1:0] & WIDTH'(`CELL_MSB_ZERO_MASK);
                `PART_ENABLE: state_d.event_enable_part =
                                  req.wdata[WIDTH-1:0] & WIDTH'(`CELL_MSB_ZERO_MASK);
                default:      ;
            endcase
        end
        // Read clears event, but a new hit in the same cycle survives
        if (req.rd && req.sel == `PART_EVENT) begin
            state_d.event_bits = hits;
        end else begin
            state_d.event_bits = state_q.event_bits | hits;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.cond                      <= '0;
            state_q.rise_filter               <= WIDTH'(`CELL_RISE_RESET);
            state_q.falling_transition_filter <= WIDTH'(`CELL_FILTER_RESET);
            state_q.event_bits                <= '0;
            state_q.event_enable_part         <= WIDTH'(`CELL_ENABLE_RESET);
            state_q.rdata                     <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata   = state_q.rdata;
    assign summary = |(state_q.event_bits & state_q.event_enable_part);

endmodule

// ==== logic/status_cfg.svh ====
// Offsets, field positions, reset values and widths of the status reporting logic
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

// ****************************************
// Status register cell
// ****************************************
`define CELL_WIDTH          16
`define CELL_MSB_ZERO_MASK  16'h7fff
`define CELL_FILTER_RESET   16'h0000
`define CELL_RISE_RESET     16'h7fff
`define CELL_ENABLE_RESET   16'h0000

// ****************************************
// Status byte bit positions
// ****************************************
`define SB_ERRQ_BIT         2
`define SB_QUES_BIT         3
`define SB_MAV_BIT          4
`define SB_ESB_BIT          5
`define SB_MSS_BIT          6
`define SB_OPER_BIT         7
`define SB_DEFINED_MASK     8'hfc
`define SB_MASK_RESET       8'h00

// ****************************************
// Local register selects
// ****************************************
`define SEL_STATUS_BYTE     3'h0
`define SEL_SRQ_MASK        3'h1
`define SEL_POLL_MASK       3'h2
`define SEL_EVENT_STATUS    3'h3
`define SEL_EVENT_ENABLE    3'h4

// ****************************************
// Status cell part selects
// ****************************************
`define PART_CONDITION      3'h0
`define PART_RISE           3'h1
`define PART_FALL           3'h2
`define PART_EVENT          3'h3
`define PART_ENABLE         3'h4

`endif

// ==== logic/status_pkg.sv ====
// Types shared by the status reporting logic
package status_pkg;

    typedef enum logic [2:0] {
        PART_COND = 3'b000,
        PART_RISE = 3'b001,
        PART_FALL = 3'b010,
        PART_EVT  = 3'b011,
        PART_EVENT_ENABLE_PART = 3'b100
    } cell_part_t;

    // Register access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  sel;
        logic [15:0] wdata;
    } reg_req_t;

    // Poll answers towards the remote bus controller
    typedef struct packed {
        logic [7:0] status_byte;
        logic       individual_status_flag;
        logic       service_request;
    } poll_resp_t;

endpackage

// ==== logic/status_service_request_logic.sv ====
// Status byte, service request, parallel poll flag and the two summary cells
// Function
// - Falling condition sets event if fall filter set
// - Fall filter freely read and written
// - Event latches filtered transitions, read clears
// - Summary is OR of event AND enable
// - Enable part freely read and written
// - Status byte bit 6 summarises others
// - Status byte clears when software reads it
// - Masked rising status bit raises service request
// - Service request ignores mask bit 6
// - Bit 2 set on error queue entry
// - Bit 3 carries questionable summary
// - Bit 4 set when message becomes available
// - Bit 5 is enabled standard event summary
// - Bit 6 set when service requested
// - Bit 7 carries operation summary
// - Poll flag ORs status AND poll mask
// - Parallel poll presents current poll flag
// - Serial poll returns status byte
// - Rising condition sets event if rise filter
// - Condition follows live status, read only
// - Summary feeds next higher condition bit
// - Five 16-bit parts, top bit zero
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_service_request_logic #(
    parameter int CELL_WIDTH = `CELL_WIDTH
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Local register port
    input  wire status_pkg::reg_req_t  byte_req,
    output logic      [7:0]            byte_rdata,
    // Questionable and operation cells
    input  wire status_pkg::reg_req_t  ques_req,
    output logic      [CELL_WIDTH-1:0] ques_rdata,
    input  wire logic [CELL_WIDTH-1:0] ques_condition,
    input  wire status_pkg::reg_req_t  oper_req,
    output logic      [CELL_WIDTH-1:0] oper_rdata,
    input  wire logic [CELL_WIDTH-1:0] oper_condition,
    // Live instrument status
    input  wire logic                  error_queue_write,
    input  wire logic                  error_queue_empty,
    input  wire logic                  message_available,
    input  wire logic [7:0]            standard_event_set,
    // Remote bus polls
    input  wire logic                  serial_poll,
    input  wire logic                  parallel_poll,
    output status_pkg::poll_resp_t     poll_resp,
    output logic                       poll_resp_valid,
    output logic                       service_request
);
    import status_pkg::*;

    if (CELL_WIDTH != 16) begin : g_width_check
        $error("status_service_request_logic: CELL_WIDTH must be 16");
    end

    // ****************************************
    // Summary cells
    // ****************************************
    logic ques_summary;
    logic oper_summary;

    status_cell #(.WIDTH(CELL_WIDTH)) u_ques (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .condition_in (ques_condition),
        .req          (ques_req),
        .rdata        (ques_rdata),
        .summary      (ques_summary)
    );

    status_cell #(.WIDTH(CELL_WIDTH)) u_oper (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .condition_in (oper_condition),
        .req          (oper_req),
        .rdata        (oper_rdata),
        .summary      (oper_summary)
    );

    // ****************************************
    // Top-level state
    // ****************************************
    typedef struct packed {
        logic [7:0] status_byte;
        logic [7:0] service_request_mask;
        logic [7:0] poll_flag_mask;
        logic [7:0] standard_event_status;
        logic [7:0] standard_event_enable;
        logic [7:0] prev_sources;
        logic       service_request;
        logic       individual_status_flag;
        logic [7:0] rdata;
        poll_resp_t resp;
        logic       resp_valid;
    } top_state_t;

    top_state_t state_q;
    top_state_t state_d;

    function automatic logic masked_or(input logic [7:0] bits, input logic [7:0] mask);
        masked_or = |(bits & mask);
    endfunction

    logic [7:0] sources;
    logic [7:0] rises;
    logic [7:0] byte_next;
    logic       master_summary_bit;
    logic       sb_read;
    logic       esr_read;

    always_comb begin
        sb_read  = byte_req.rd && byte_req.sel == `SEL_STATUS_BYTE;
        esr_read = byte_req.rd && byte_req.sel == `SEL_EVENT_STATUS;
        sources = 8'h00;
        // Error queue bit stays up while the queue holds entries
        sources[`SB_ERRQ_BIT] = error_queue_write | ~error_queue_empty;
        sources[`SB_QUES_BIT] = ques_summary;
        sources[`SB_MAV_BIT]  = message_available;
        sources[`SB_ESB_BIT]  = masked_or(state_q.standard_event_status,
                                          state_q.standard_event_enable);
        sources[`SB_OPER_BIT] = oper_summary;
        rises = sources & ~state_q.prev_sources;

        state_d = state_q;
        state_d.prev_sources = sources;
        // Event behaviour: rising sources latch, read clears, new rise wins
        byte_next = (sb_read ? 8'h00 : state_q.status_byte) | rises;
        byte_next[`SB_MSS_BIT] = 1'b0;
        // Master summary from other bits; mask bit 6 ignored
        master_summary_bit = masked_or(byte_next & ~8'h40, state_q.service_request_mask & ~8'h40);
        byte_next[`SB_MSS_BIT] = master_summary_bit;
        state_d.status_byte = byte_next & `SB_DEFINED_MASK;
        state_d.service_request = masked_or(rises, state_q.service_request_mask & ~8'h40) |
                                  (master_summary_bit & state_q.service_request);
        state_d.individual_status_flag = masked_or(state_d.status_byte,
                                                   state_q.poll_flag_mask);

        state_d.standard_event_status = (esr_read ? 8'h00 : state_q.standard_event_status)
                                        | standard_event_set;

        if (byte_req.rd) begin
            unique case (byte_req.sel)
                `SEL_STATUS_BYTE:  state_d.rdata = state_q.status_byte;
                `SEL_SRQ_MASK:     state_d.rdata = state_q.service_request_mask;
                `SEL_POLL_MASK:    state_d.rdata = state_q.poll_flag_mask;
                `SEL_EVENT_STATUS: state_d.rdata = state_q.standard_event_status;
                `SEL_EVENT_ENABLE: state_d.rdata = state_q.standard_event_enable;
                default:           state_d.rdata = 8'h00;
            endcase
        end
        if (byte_req.wr) begin
            unique case (byte_req.sel)
                `SEL_SRQ_MASK:     state_d.service_request_mask  = byte_req.wdata[7:0];
                `SEL_POLL_MASK:    state_d.poll_flag_mask        = byte_req.wdata[7:0];
                `SEL_EVENT_ENABLE: state_d.standard_event_enable = byte_req.wdata[7:0];
                default:           ;
            endcase
        end

        // Polls answer with the current registered values
        state_d.resp_valid = serial_poll | parallel_poll;
        if (serial_poll) begin
            state_d.resp.status_byte = state_q.status_byte;
        end
        if (parallel_poll) begin
            state_d.resp.individual_status_flag = state_q.individual_status_flag;
        end
        state_d.resp.service_request = state_q.service_request;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign byte_rdata      = state_q.rdata;
    assign poll_resp       = state_q.resp;
    assign poll_resp_valid = state_q.resp_valid;
    assign service_request = state_q.service_request;

endmodule

// ==== tb/poll_master_model.sv ====
// Remote bus controller model issuing serial and parallel polls
`timescale 1ns/1ps

module poll_master_model
    import status_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire status_pkg::poll_resp_t poll_resp,
    input  wire logic                   poll_resp_valid,
    output logic                        serial_poll,
    output logic                        parallel_poll
);
    initial begin
        serial_poll = 1'b0;
        parallel_poll = 1'b0;
    end

    // One-cycle poll pulse, answer taken once valid shows (bounded wait)
    task automatic poll(input logic par, output logic [7:0] sbyte, output logic flag);
        int n;
        n = 0;
        @(posedge core_clk);
        serial_poll <= !par;
        parallel_poll <= par;
        @(posedge core_clk);
        serial_poll <= 1'b0;
        parallel_poll <= 1'b0;
        #1;
        while (poll_resp_valid !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        sbyte = poll_resp.status_byte;
        flag = poll_resp.individual_status_flag;
    endtask
endmodule

// ==== tb/status_service_request_logic_bench.sv ====
// Self-checking bench for status byte, service request and polls
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_service_request_logic_bench;
    import status_pkg::*;
    logic       core_clk = 1'b0;
    logic       reset_n = 1'b0;
    reg_req_t   byte_req = '0, ques_req = '0, oper_req = '0;
    logic [7:0] byte_rdata, sp_q, std_set = 8'h00;
    logic [15:0] ques_rdata, oper_rdata, rd_q, ques_cond = 16'h0000, oper_cond = 16'h0000;
    logic       eq_write = 1'b0, eq_empty = 1'b1, msg_avail = 1'b0;
    logic       serial_poll, parallel_poll, poll_resp_valid, service_request, flag_q;
    poll_resp_t poll_resp;
    int         fails = 0;
    int         tests_run = 0;

    always #2.5 core_clk = ~core_clk;

    status_service_request_logic #(.CELL_WIDTH(16)) status_service_request_logic_i (
        .core_clk(core_clk), .reset_n(reset_n), .byte_req(byte_req), .byte_rdata(byte_rdata),
        .ques_req(ques_req), .ques_rdata(ques_rdata), .ques_condition(ques_cond),
        .oper_req(oper_req), .oper_rdata(oper_rdata), .oper_condition(oper_cond),
        .error_queue_write(eq_write), .error_queue_empty(eq_empty), .message_available(msg_avail),
        .standard_event_set(std_set), .serial_poll(serial_poll), .parallel_poll(parallel_poll),
        .poll_resp(poll_resp), .poll_resp_valid(poll_resp_valid), .service_request(service_request));

    poll_master_model poll_master_model_i (.core_clk(core_clk), .poll_resp(poll_resp),
        .poll_resp_valid(poll_resp_valid), .serial_poll(serial_poll), .parallel_poll(parallel_poll));

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic access(input int unit, input logic wr, input logic [2:0] sel, input logic [15:0] data);
        reg_req_t r;
        r = '{rd: !wr, wr: wr, sel: sel, wdata: data};
        @(posedge core_clk);
        if (unit == 0) byte_req <= r; else if (unit == 1) ques_req <= r; else oper_req <= r;
        @(posedge core_clk);
        if (unit == 0) byte_req <= '0; else if (unit == 1) ques_req <= '0; else oper_req <= '0;
        #1;
        rd_q = (unit == 0) ? {8'h00, byte_rdata} : (unit == 1) ? ques_rdata : oper_rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic rd(input int unit, input logic [2:0] sel, input logic [15:0] exp, input string msg);
        access(unit, 1'b0, sel, 16'h0000);
        chk(rd_q, exp, msg);
    endtask

    task automatic poll(input logic par, input logic [7:0] exp_byte, input logic exp_flag);
        poll_master_model_i.poll(par, sp_q, flag_q);
        chk({15'h0000, poll_resp_valid}, 16'h0001, "poll answered");
        if (par) chk({15'h0000, flag_q}, {15'h0000, exp_flag}, "poll flag");
        else chk({8'h00, sp_q}, {8'h00, exp_byte}, "serial byte");
    endtask

    task automatic settle();
        repeat (4) @(posedge core_clk);
        {eq_write, std_set} <= 9'h000;
        repeat (2) @(posedge core_clk);
        // Outputs looked at after settle are read off the edge
        #1;
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(0, `SEL_STATUS_BYTE, 16'h0000, "byte reset");
        rd(0, 3'h7, 16'h0000, "unknown select");
        rd(1, `PART_RISE, `CELL_RISE_RESET, "rise reset");
        access(1, 1'b1, `PART_RISE, 16'h0002);
        access(1, 1'b1, `PART_ENABLE, 16'h0001);
        access(2, 1'b1, `PART_FALL, 16'h8005);
        rd(2, `PART_FALL, 16'h0005, "fall readback");
        rd(2, `PART_FALL, 16'h0005, "fall reread");
        rd(1, `PART_ENABLE, 16'h0001, "enable readback");
        @(posedge core_clk);
        ques_cond <= 16'h0003;
        settle();
        rd(1, `PART_EVENT, 16'h0002, "rise event");
        rd(1, `PART_EVENT, 16'h0000, "event cleared");
        rd(1, `PART_CONDITION, 16'h0003, "condition");
        rd(0, `SEL_STATUS_BYTE, 16'h0000, "unenabled event");
        // Filter must stand before the condition falls, else no event
        access(1, 1'b1, `PART_FALL, 16'h0001);
        @(posedge core_clk);
        ques_cond <= 16'h0000;
        settle();
        rd(0, `SEL_STATUS_BYTE, 16'h0008, "questionable bit");
        rd(1, `PART_EVENT, 16'h0001, "fall event");
        access(0, 1'b1, `SEL_SRQ_MASK, 16'h0080);
        access(0, 1'b1, `SEL_POLL_MASK, 16'h0040);
        access(2, 1'b1, `PART_ENABLE, 16'h0004);
        @(posedge core_clk);
        oper_cond <= 16'h0004;
        settle();
        chk({15'h0000, service_request}, 16'h0001, "srq on masked rise");
        poll(1'b0, 8'hc0, 1'b0);
        poll(1'b1, 8'h00, 1'b1);
        rd(0, `SEL_SRQ_MASK, 16'h0080, "mask readback");
        rd(0, `SEL_STATUS_BYTE, 16'h00c0, "byte read");
        poll(1'b0, 8'h00, 1'b0);
        chk({15'h0000, service_request}, 16'h0000, "srq dropped");
        access(0, 1'b1, `SEL_SRQ_MASK, 16'h0040);
        @(posedge core_clk);
        eq_empty <= 1'b0;
        eq_write <= 1'b1;
        settle();
        chk({15'h0000, service_request}, 16'h0000, "mask bit six");
        poll(1'b0, 8'h04, 1'b0);
        poll(1'b1, 8'h00, 1'b0);
        @(posedge core_clk);
        eq_empty <= 1'b1;
        rd(0, `SEL_STATUS_BYTE, 16'h0004, "error bit read");
        access(0, 1'b1, `SEL_EVENT_ENABLE, 16'h0001);
        access(0, 1'b1, `SEL_SRQ_MASK, 16'h0010);
        @(posedge core_clk);
        msg_avail <= 1'b1;
        std_set <= 8'h01;
        settle();
        chk({15'h0000, service_request}, 16'h0001, "srq message");
        poll(1'b0, 8'h70, 1'b0);
        @(posedge core_clk);
        msg_avail <= 1'b0;
        rd(0, `SEL_EVENT_STATUS, 16'h0001, "event status");
        rd(0, `SEL_STATUS_BYTE, 16'h0070, "byte read two");
        rd(0, `SEL_STATUS_BYTE, 16'h0000, "byte cleared");
        results();
    end

    // Run needs well under 1000 cycles
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule

// ==== tb/status_srq_sva.sv ====
// Port assertions for the status byte, poll answer and status cells
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_srq_checker
    import status_pkg::*;
#(
    parameter int CELL_WIDTH = `CELL_WIDTH
) (
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire status_pkg::reg_req_t  byte_req,
    input wire logic [7:0]            byte_rdata,
    input wire status_pkg::reg_req_t  ques_req,
    input wire logic [CELL_WIDTH-1:0] ques_rdata,
    input wire logic [CELL_WIDTH-1:0] ques_condition,
    input wire status_pkg::reg_req_t  oper_req,
    input wire logic [CELL_WIDTH-1:0] oper_rdata,
    input wire logic                  serial_poll,
    input wire logic                  parallel_poll,
    input wire status_pkg::poll_resp_t poll_resp,
    input wire logic                  poll_resp_valid,
    input wire logic                  service_request
);
    // ****************************************
    // Shadows of the SRQ mask, questionable enable part and operation fall filter
    // ****************************************
    logic [7:0]  mask_q;
    logic [15:0] event_enable_part_q;
    logic [15:0] fall_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= `SB_MASK_RESET;
            event_enable_part_q <= `CELL_ENABLE_RESET;
            fall_q <= `CELL_FILTER_RESET;
        end else begin
            if (byte_req.wr && byte_req.sel == `SEL_SRQ_MASK) mask_q <= byte_req.wdata[7:0];
            if (ques_req.wr && ques_req.sel == `PART_ENABLE) event_enable_part_q <= ques_req.wdata & `CELL_MSB_ZERO_MASK;
            if (oper_req.wr && oper_req.sel == `PART_FALL) fall_q <= oper_req.wdata & `CELL_MSB_ZERO_MASK;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    poll_answer_a: assert property ((serial_poll || parallel_poll) |=> poll_resp_valid)
        else $error("poll not answered");
    poll_quiet_a: assert property (!(serial_poll || parallel_poll) |=> !poll_resp_valid)
        else $error("answer without poll");
    undef_zero_a: assert property (poll_resp_valid |-> poll_resp.status_byte[1:0] == 2'b00)
        else $error("undefined status bits set");
    cell_msb_a: assert property ((ques_req.rd || oper_req.rd) |=> !ques_rdata[15] && !oper_rdata[15])
        else $error("cell top bit set");
    mask_rw_a: assert property (byte_req.rd && byte_req.sel == `SEL_SRQ_MASK |=> byte_rdata == mask_q)
        else $error("mask readback wrong");
    enable_rw_a: assert property (ques_req.rd && ques_req.sel == `PART_ENABLE |=> ques_rdata == event_enable_part_q)
        else $error("enable readback wrong");
    fall_rw_a: assert property (oper_req.rd && oper_req.sel == `PART_FALL |=> oper_rdata == fall_q)
        else $error("fall filter readback wrong");
    cond_follow_a: assert property ($stable(ques_condition) [*3]
        ##0 (ques_req.rd && ques_req.sel == `PART_CONDITION)
        |=> ques_rdata == ($past(ques_condition) & `CELL_MSB_ZERO_MASK))
        else $error("condition read wrong");
    poll_srq_a: assert property (poll_resp_valid |-> poll_resp.service_request == $past(service_request))
        else $error("poll request flag stale");

    cover property ($rose(service_request));
    cover property (poll_resp_valid && poll_resp.individual_status_flag);
    cover property (serial_poll ##1 poll_resp_valid);
endmodule

bind status_service_request_logic status_srq_checker #(.CELL_WIDTH(CELL_WIDTH)) status_srq_checker_i (
    .core_clk(core_clk), .reset_n(reset_n), .byte_req(byte_req), .byte_rdata(byte_rdata),
    .ques_req(ques_req), .ques_rdata(ques_rdata), .ques_condition(ques_condition), .oper_req(oper_req),
    .oper_rdata(oper_rdata), .serial_poll(serial_poll), .parallel_poll(parallel_poll),
    .poll_resp(poll_resp), .poll_resp_valid(poll_resp_valid), .service_request(service_request));
